// ===== verif/pdlpc_chk.sv
// concurrent checks on the register bus and claim outputs
`timescale 1ns/100ps
module pdlpc_chk (
  input wire        clk_sys_in,
  input wire        rst_in,
  input wire        hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0]  htrans_in,
  input wire        hwrite_in,
  input wire        hready_in,
  input wire [31:0] hrdata_out,
  input wire        pci_frame_n_in,
  input wire        pci_devsel_n_out,
  input wire        pci_devsel_oe_out,
  input wire        claim_positive_out,
  input wire        claim_subtractive_out,
  input wire        fwd_secondary_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  sequence rd_at(a);
    hsel_in && hready_in && htrans_in == 2'h2 && !hwrite_in && haddr_in == a;
  endsequence
  sequence frame_idle;
    pci_frame_n_in [*8];
  endsequence
  ctrl_reserved_zero_a: assert property (rd_at(32'h15c) |=> hrdata_out[7:2] == 6'h0)
    else $error("decode ctrl reserved bits set");
  port_bit7_zero_a: assert property (rd_at(32'h160) |=> !hrdata_out[7])
    else $error("port enable bit 7 set");
  class_mirror_only_a: assert property (rd_at(32'h24) |=> hrdata_out[31:1] == 31'h0)
    else $error("class code read shows more than the enable");
  fwd_follows_claim_a: assert property (fwd_secondary_out ==
    (claim_positive_out || claim_subtractive_out)) else $error("forward without claim");
  one_claim_kind_a: assert property (!(claim_positive_out && claim_subtractive_out))
    else $error("both claim kinds held");
  devsel_claim_a: assert property (!pci_devsel_n_out == fwd_secondary_out)
    else $error("devsel differs from claim");
  devsel_driven_a: assert property (!pci_devsel_n_out |-> pci_devsel_oe_out)
    else $error("devsel low but not driven");
  claim_release_a: assert property (frame_idle |-> !fwd_secondary_out)
    else $error("claim held after frame ended");
  claim_in_frame_a: assert property ($rose(fwd_secondary_out) |-> !pci_frame_n_in)
    else $error("claim outside a frame");
endmodule // pdlpc_chk

// ===== verif/pdlpc_pci_mst.sv
// primary bus master model issuing one cycle at a time
`timescale 1ns/100ps
module pdlpc_pci_mst (
  input  wire         clk_sys_in,
  input  wire         claim_pos_in,
  input  wire         claim_sub_in,
  output logic        frame_n_out,
  output logic        devsel_n_out,
  output logic [31:0] ad_out,
  output logic [3:0]  cbe_n_out
);
  logic pos_seen;
  logic sub_seen;
  int   sub_lat;
  initial begin
    frame_n_out = 1'b1;
    devsel_n_out = 1'b1;
    ad_out = 32'h0;
    cbe_n_out = 4'hf;
  end
  // other: a fast target claims the cycle first
  task run(input [31:0] a, input [3:0] cmd, input other);
    pos_seen = 0;
    sub_seen = 0;
    sub_lat = 0;
    @(posedge clk_sys_in);
    frame_n_out <= 1'b0;
    ad_out <= a;
    cbe_n_out <= ~cmd;
    for (int i = 1; i <= 14; i++) begin
      @(posedge clk_sys_in);
      if (other && i == 1) devsel_n_out <= 1'b0;
      if (claim_pos_in) pos_seen = 1;
      if (claim_sub_in && !sub_seen) begin
        sub_seen = 1;
        sub_lat = i;
      end
    end
    // address and command lines show the inverse of the last value; frame and devsel go high
    frame_n_out <= 1'b1;
    devsel_n_out <= 1'b1;
    ad_out <= ~a;
    cbe_n_out <= cmd;
    repeat (10) @(posedge clk_sys_in);
  endtask
endmodule // pdlpc_pci_mst

// ===== verif/pdlpc_tb_top.sv
// self-checking bench for primary decode and legacy port claim
`timescale 1ns/100ps
module pdlpc_tb_top;
  logic        clk_sys_in, rst_in, hsel, hwrite;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire         hrdy, hresp, dsel_n, dsel_oe, cpos, csub, fwd, frame_n, odev_n;
  wire  [31:0] hrdata, ad;
  wire  [3:0]  cbe_n;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          l1;
  // {hit, enable bit, address}
  logic [15:0] rows [20] = '{16'h83f8, 16'h83ff, 16'h03f7, 16'h92f8, 16'h92ff, 16'h1300,
    16'ha3e8, 16'ha3ef, 16'hb2e8, 16'hb2ef, 16'h32f0, 16'hc3bc, 16'hc7bf, 16'h43bb,
    16'hd378, 16'hd77b, 16'h577c, 16'he27f, 16'he678, 16'h667c};

  pdlpc_top #(.PRI_SUB_EN_RESET(1'b0)) i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hrdy), .hreadyout_out(hrdy),
    .hresp_out(hresp), .hrdata_out(hrdata), .pci_frame_n_in(frame_n), .pci_devsel_n_in(odev_n),
    .pci_ad_in(ad), .pci_cbe_n_in(cbe_n), .pci_devsel_n_out(dsel_n),
    .pci_devsel_oe_out(dsel_oe), .claim_positive_out(cpos), .claim_subtractive_out(csub),
    .fwd_secondary_out(fwd));
  pdlpc_pci_mst u_mst (.clk_sys_in(clk_sys_in), .claim_pos_in(cpos), .claim_sub_in(csub),
    .frame_n_out(frame_n), .devsel_n_out(odev_n), .ad_out(ad), .cbe_n_out(cbe_n));

  initial begin
    clk_sys_in = 0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  task ahb(input [31:0] a, input w, input [31:0] d);
    @(posedge clk_sys_in);
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    do @(posedge clk_sys_in); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys_in); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask

  task chk(input [31:0] exp, input [31:0] got, input string nm);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk_sys_in);
    error_cnt++;
    $display("watchdog expired");
    finish_test;
  end

  initial begin
    rst_in = 1;
    hsel = 1;
    hwrite = 0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 0;
    repeat (4) @(posedge clk_sys_in);
    foreach (rows[i]) begin
      ahb(32'h160, 1'b1, 32'h1 << rows[i][14:12]);
      ahb(32'h168, 1'b1, 32'h1 << rows[i][14:12]);
      u_mst.run({20'h0, rows[i][11:0]}, i[0] ? 4'h3 : 4'h2, 1'b0);
      chk({31'h0, rows[i][15]}, {31'h0, u_mst.pos_seen}, "positive claim");
    end
    $display("test port ranges done");
    ahb(32'h15c, 1'b1, 32'hff);
    ahb(32'h15c, 1'b0, 32'h0);
    chk(32'h3, rd, "decode ctrl");
    ahb(32'h160, 1'b1, 32'hff);
    ahb(32'h160, 1'b0, 32'h0);
    chk(32'h7f, rd, "port enable");
    ahb(32'h24, 1'b0, 32'h0);
    chk(32'h1, rd & 32'h1, "class mirror on");
    ahb(32'h200, 1'b0, 32'h0);
    chk(32'h0, rd, "unmapped read");
    chk(32'h0, {31'h0, hresp}, "okay response");
    $display("test registers done");
    ahb(32'h160, 1'b1, 32'h1);
    ahb(32'h168, 1'b1, 32'h0);
    ahb(32'h15c, 1'b1, 32'h1);
    u_mst.run(32'h3f8, 4'h2, 1'b0);
    chk(32'h0, {31'h0, u_mst.pos_seen | u_mst.sub_seen}, "excluded claim");
    u_mst.run(32'h500, 4'h2, 1'b0);
    chk(32'h1, {31'h0, u_mst.sub_seen}, "normal subtractive");
    l1 = u_mst.sub_lat;
    ahb(32'h16c, 1'b0, 32'h0);
    chk(32'h8, rd, "claim status");
    u_mst.run(32'h500, 4'h2, 1'b1);
    chk(32'h0, {31'h0, u_mst.sub_seen}, "claimed elsewhere");
    ahb(32'h15c, 1'b1, 32'h3);
    u_mst.run(32'h500, 4'h3, 1'b0);
    chk(l1 + 1, u_mst.sub_lat, "slow slot");
    ahb(32'h15c, 1'b1, 32'h2);
    u_mst.run(32'h500, 4'h3, 1'b0);
    chk(32'h0, {31'h0, u_mst.sub_seen}, "slow without enable");
    ahb(32'h24, 1'b0, 32'h0);
    chk(32'h0, rd & 32'h1, "class mirror off");
    $display("test subtractive done");
    rst_in <= 1;
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 0;
    repeat (4) @(posedge clk_sys_in);
    ahb(32'h15c, 1'b0, 32'h0);
    chk(32'h0, rd, "ctrl reset");
    ahb(32'h160, 1'b0, 32'h0);
    chk(32'h0, rd, "enable reset");
    u_mst.run(32'h3f8, 4'h2, 1'b0);
    chk(32'h0, {31'h0, u_mst.pos_seen}, "claim after reset");
    $display("test reset done");
    finish_test;
  end
endmodule // pdlpc_tb_top

bind pdlpc_top pdlpc_chk u_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
  .hrdata_out(hrdata_out), .pci_frame_n_in(pci_frame_n_in),
  .pci_devsel_n_out(pci_devsel_n_out), .pci_devsel_oe_out(pci_devsel_oe_out),
  .claim_positive_out(claim_positive_out), .claim_subtractive_out(claim_subtractive_out),
  .fwd_secondary_out(fwd_secondary_out));

// ===== verilog/pdlpc_regs.vh
// register map, field positions and timing counts for primary decode and legacy port claim
// Overview of operation
// - decode control bits 7..2 ignore writes and read as zero
// - subtractive enable mirrored into class code register bit 0
// - control bit 0 enables claiming unclaimed non-configuration primary cycles for the secondary bus
// - control bit 1 picks slow decode slot, only while bit 0 set
// - slow subtractive decode claims four clocks after frame asserted
// - port enable register bit 7 reads as zero
// - bit 6 decodes 278h-27Fh and 678h-67Bh
// - bit 5 decodes 378h-37Fh and 778h-77Bh
// - bit 4 decodes 3BCh-3BFh and 7BCh-7BFh
// - bit 3 decodes 2E8h-2EFh
// - bit 2 decodes 3E8h-3EFh
// - bit 1 decodes 2F8h-2FFh
// - bit 0 decodes 3F8h-3FFh
// - forwarding of each enabled range follows same map bit
// - port enable register resets to zero
// - cleared map bit with enable bit set means range never claimed, even subtractively
`ifndef PDLPC_REGS_VH
`define PDLPC_REGS_VH

// register indices; byte address is four times the index
`define PDLPC_IDX_CLASS_CODE  8'h09
`define PDLPC_IDX_PRI_CTRL    8'h57
`define PDLPC_IDX_PORT_EN     8'h58
`define PDLPC_IDX_PORT_MAP    8'h5a
`define PDLPC_IDX_STATUS      8'h5b

`define PDLPC_RST_PRI_CTRL    8'h00
`define PDLPC_RST_PORT_EN     8'h00
`define PDLPC_RST_PORT_MAP    8'h00

`define PDLPC_BIT_SUB_EN      0
`define PDLPC_BIT_SUB_SLOW    1
`define PDLPC_PRI_CTRL_MASK   8'h03
`define PDLPC_PORT_MASK       8'h7f

// claim slots in clocks after frame is seen asserted
`define PDLPC_POS_CLKS        3'h1
`define PDLPC_SUB_FAST_CLKS   3'h3
`define PDLPC_SUB_SLOW_CLKS   3'h4

`define PDLPC_CMD_IO_RD       4'h2
`define PDLPC_CMD_IO_WR       4'h3
`define PDLPC_CMD_CFG_RD      4'ha
`define PDLPC_CMD_CFG_WR      4'hb

`define PDLPC_HTRANS_NONSEQ   2'h2

`endif

// ===== verilog/pdlpc_top.v
// primary-side subtractive decode and legacy port claim with ahb-lite register access
`timescale 1ns/100ps
`include "pdlpc_regs.vh"

module pdlpc_top #(
  parameter [0:0] PRI_SUB_EN_RESET = 1'b0
) (
  input  wire        clk_sys_in,
  input  wire        rst_in,
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output reg         hreadyout_out,
  output reg         hresp_out,
  output reg  [31:0] hrdata_out,
  input  wire        pci_frame_n_in,
  input  wire        pci_devsel_n_in,
  input  wire [31:0] pci_ad_in,
  input  wire [3:0]  pci_cbe_n_in,
  output reg         pci_devsel_n_out,
  output reg         pci_devsel_oe_out,
  output reg         claim_positive_out,
  output reg         claim_subtractive_out,
  output reg         fwd_secondary_out
);

  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_WAIT  = 4'b0010;
  localparam [3:0] ST_CLAIM = 4'b0100;
  localparam [3:0] ST_PASS  = 4'b1000;

  // one bit per legacy range, bit n matches enable bit n
  function [6:0] port_hits;
    input [31:0] a;
    reg          hi_zero;
    begin
      hi_zero = (a[31:11] == 21'h000000);
      port_hits[0] = hi_zero && (a[10:3] == 8'h7f);
      port_hits[1] = hi_zero && (a[10:3] == 8'h5f);
      port_hits[2] = hi_zero && (a[10:3] == 8'h7d);
      port_hits[3] = hi_zero && (a[10:3] == 8'h5d);
      port_hits[4] = hi_zero && ((a[10:2] == 9'h0ef) || (a[10:2] == 9'h1ef));
      port_hits[5] = hi_zero && ((a[10:3] == 8'h6f) || (a[10:2] == 9'h1de));
      port_hits[6] = hi_zero && ((a[10:3] == 8'h4f) || (a[10:2] == 9'h19e));
    end
  endfunction

  // register index decode, shared by read and write paths
  function is_idx;
    input [31:0] a;
    input [7:0]  idx;
    begin
      is_idx = (a[31:10] == 22'h000000) && (a[9:2] == idx) && (a[1:0] == 2'h0);
    end
  endfunction

  reg  [1:0]  pri_ctrl_q;
  reg  [1:0]  pri_ctrl_d;
  reg  [6:0]  port_en_q;
  reg  [6:0]  port_en_d;
  reg  [6:0]  port_map_q;
  reg  [6:0]  port_map_d;
  reg  [7:0]  status_q;
  reg  [7:0]  status_d;

  reg         wr_pend_q;
  reg  [31:0] wr_addr_q;

  // three-flop pin inputs with agreement filter
  reg  [37:0] pin_s1_q;
  reg  [37:0] pin_s2_q;
  reg  [37:0] pin_s3_q;
  reg  [37:0] pin_f_q;
  wire [37:0] pin_raw;
  wire [37:0] pin_agree;
  wire [37:0] pin_f_d;

  assign pin_raw   = {pci_frame_n_in, pci_devsel_n_in, pci_cbe_n_in, pci_ad_in};
  assign pin_agree = ~(pin_s2_q ^ pin_s3_q);
  assign pin_f_d   = (pin_agree & pin_s3_q) | (~pin_agree & pin_f_q);

  wire        frame_n_f;
  wire        devsel_n_f;
  wire [3:0]  cmd_f;
  wire [31:0] ad_f;
  assign frame_n_f  = pin_f_q[37];
  assign devsel_n_f = pin_f_q[36];
  assign cmd_f      = ~pin_f_q[35:32];
  assign ad_f       = pin_f_q[31:0];

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pin_s1_q <= {38{1'b1}};
      pin_s2_q <= {38{1'b1}};
      pin_s3_q <= {38{1'b1}};
      pin_f_q  <= {38{1'b1}};
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q  <= pin_f_d;
    end
  end

  // ahb-lite slave: zero wait states, write lands in its data phase
  wire ahb_req;
  assign ahb_req = hsel_in && hready_in && (htrans_in == `PDLPC_HTRANS_NONSEQ);

  always @* begin
    pri_ctrl_d = pri_ctrl_q;
    port_en_d  = port_en_q;
    port_map_d = port_map_q;
    if (wr_pend_q) begin
      if (is_idx(wr_addr_q, `PDLPC_IDX_PRI_CTRL)) begin
        pri_ctrl_d = hwdata_in[1:0];
      end
      if (is_idx(wr_addr_q, `PDLPC_IDX_PORT_EN)) begin
        port_en_d = hwdata_in[6:0];
      end
      if (is_idx(wr_addr_q, `PDLPC_IDX_PORT_MAP)) begin
        port_map_d = hwdata_in[6:0];
      end
    end
  end

  // reads see a write finishing in the same cycle
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (is_idx(haddr_in, `PDLPC_IDX_CLASS_CODE)) begin
      rd_byte = {7'h00, pri_ctrl_d[`PDLPC_BIT_SUB_EN]};
    end else if (is_idx(haddr_in, `PDLPC_IDX_PRI_CTRL)) begin
      rd_byte = {6'h00, pri_ctrl_d};
    end else if (is_idx(haddr_in, `PDLPC_IDX_PORT_EN)) begin
      rd_byte = {1'b0, port_en_d};
    end else if (is_idx(haddr_in, `PDLPC_IDX_PORT_MAP)) begin
      rd_byte = {1'b0, port_map_d};
    end else if (is_idx(haddr_in, `PDLPC_IDX_STATUS)) begin
      rd_byte = status_d;
    end
  end

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      // control resets to zero, enable from parameter
      pri_ctrl_q    <= {1'b0, PRI_SUB_EN_RESET};
      // no legacy range decoded after reset
      port_en_q     <= 7'h00;
      port_map_q    <= 7'h00;
      wr_pend_q     <= 1'b0;
      wr_addr_q     <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      hrdata_out    <= 32'h00000000;
    end else begin
      pri_ctrl_q    <= pri_ctrl_d;
      port_en_q     <= port_en_d;
      port_map_q    <= port_map_d;
      wr_pend_q     <= ahb_req && hwrite_in;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      if (ahb_req) begin
        wr_addr_q <= haddr_in;
      end
      if (ahb_req && !hwrite_in) begin
        hrdata_out <= {24'h000000, rd_byte};
      end
    end
  end

  // primary cycle decode
  reg  [3:0]  state_q;
  reg  [3:0]  state_d;
  reg  [2:0]  cnt_q;
  reg  [2:0]  cnt_d;
  reg         pos_hit_q;
  reg         pos_hit_d;
  reg         excl_q;
  reg         excl_d;
  reg         sub_ok_q;
  reg         sub_ok_d;
  reg         claim_pos_d;
  reg         claim_sub_d;

  wire        sub_en;
  wire        sub_slow;
  wire [2:0]  sub_slot;
  wire        is_io;
  wire        is_cfg;
  wire [6:0]  hits;

  assign sub_en   = pri_ctrl_q[`PDLPC_BIT_SUB_EN];
  assign sub_slow = sub_en && pri_ctrl_q[`PDLPC_BIT_SUB_SLOW];
  // slow slot four clocks after frame
  assign sub_slot = sub_slow ? `PDLPC_SUB_SLOW_CLKS : `PDLPC_SUB_FAST_CLKS;
  assign is_io    = (cmd_f == `PDLPC_CMD_IO_RD) || (cmd_f == `PDLPC_CMD_IO_WR);
  assign is_cfg   = (cmd_f == `PDLPC_CMD_CFG_RD) || (cmd_f == `PDLPC_CMD_CFG_WR);
  assign hits     = is_io ? port_hits(ad_f) : 7'h00;

  always @* begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    pos_hit_d   = pos_hit_q;
    excl_d      = excl_q;
    sub_ok_d    = sub_ok_q;
    claim_pos_d = claim_positive_out;
    claim_sub_d = claim_subtractive_out;
    case (state_q)
      ST_IDLE: begin
        claim_pos_d = 1'b0;
        claim_sub_d = 1'b0;
        if (!frame_n_f) begin
          pos_hit_d = |(hits & port_en_q & port_map_q);
          // enabled but unmapped range is never claimed
          excl_d    = |(hits & port_en_q & ~port_map_q);
          // relies on host keeping one subtractive decoder
          sub_ok_d  = sub_en && !is_cfg;
          cnt_d     = 3'h1;
          state_d   = ST_WAIT;
        end
      end
      ST_WAIT: begin
        cnt_d = cnt_q + 3'h1;
        if (!devsel_n_f || excl_q) begin
          state_d = ST_PASS;
        end else if (pos_hit_q && (cnt_q >= `PDLPC_POS_CLKS)) begin
          claim_pos_d = 1'b1;
          state_d     = ST_CLAIM;
        end else if (!pos_hit_q && sub_ok_q && (cnt_q >= sub_slot)) begin
          claim_sub_d = 1'b1;
          state_d     = ST_CLAIM;
        end else if (!pos_hit_q && !sub_ok_q) begin
          state_d = ST_PASS;
        end
      end
      ST_CLAIM: begin
        if (frame_n_f) begin
          claim_pos_d = 1'b0;
          claim_sub_d = 1'b0;
          state_d     = ST_IDLE;
        end
      end
      ST_PASS: begin
        if (frame_n_f) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        claim_pos_d = 1'b0;
        claim_sub_d = 1'b0;
        state_d     = ST_IDLE;
      end
    endcase
  end

  // status: current claim and last claim kind
  always @* begin
    status_d = status_q;
    if (claim_pos_d && !claim_positive_out) begin
      status_d[3:2] = 2'h1;
    end
    if (claim_sub_d && !claim_subtractive_out) begin
      status_d[3:2] = 2'h2;
    end
    status_d[1] = claim_sub_d;
    status_d[0] = claim_pos_d;
  end

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_q               <= ST_IDLE;
      cnt_q                 <= 3'h0;
      pos_hit_q             <= 1'b0;
      excl_q                <= 1'b0;
      sub_ok_q              <= 1'b0;
      status_q              <= 8'h00;
      claim_positive_out    <= 1'b0;
      claim_subtractive_out <= 1'b0;
      fwd_secondary_out     <= 1'b0;
      pci_devsel_n_out      <= 1'b1;
      pci_devsel_oe_out     <= 1'b0;
    end else begin
      state_q               <= state_d;
      cnt_q                 <= cnt_d;
      pos_hit_q             <= pos_hit_d;
      excl_q                <= excl_d;
      sub_ok_q              <= sub_ok_d;
      status_q              <= status_d;
      claim_positive_out    <= claim_pos_d;
      claim_subtractive_out <= claim_sub_d;
      fwd_secondary_out     <= claim_pos_d || claim_sub_d;
      pci_devsel_n_out      <= !(claim_pos_d || claim_sub_d);
      pci_devsel_oe_out     <= claim_pos_d || claim_sub_d;
    end
  end

endmodule // pdlpc_top
